// ### smr_pkg.sv
// Purpose: Constants and types shared by the serial mode select and
//          receive status block.
// Assumes: 16-bit CPU register address space, 8-bit registers.
// Notes:   Offsets are byte addresses of the CPU register space.
package smr_pkg;

   // ==========================================================
   // Register map
   localparam logic [15:0] ASYNC_MODE_CONTROL_ADDR = 16'hff70;
   localparam logic [15:0] ASYNC_RX_ERROR_STATUS_ADDR = 16'hff71;
   localparam logic [15:0] CLOCKED_SERIAL_MODE_CONTROL_ADDR = 16'hff72;
   localparam logic [15:0] RECEIVE_BUFFER_ADDR = 16'hff74;

   localparam logic [7:0] ASYNC_MODE_CONTROL_RST = 8'h00;
   localparam logic [7:0] ASYNC_RX_ERROR_STATUS_RST = 8'h00;
   localparam logic [7:0] CLOCKED_SERIAL_MODE_CONTROL_RST = 8'h00;
   localparam logic [7:0] RECEIVE_BUFFER_RST = 8'h00;

   // Writable bits; the rest are fixed at zero
   localparam logic [7:0] ASYNC_MODE_CONTROL_WMASK = 8'hfc;
   localparam logic [7:0] CLOCKED_SERIAL_MODE_CONTROL_WMASK = 8'h86;

   // ==========================================================
   // Field positions
   localparam int ASYNC_TX_ENABLE_BIT = 7;
   localparam int ASYNC_RX_ENABLE_BIT = 6;
   localparam int PARITY_SEL_HI_BIT = 5;
   localparam int PARITY_SEL_LO_BIT = 4;
   localparam int CHAR_LENGTH_BIT = 3;
   localparam int STOP_LENGTH_SELECT_BIT = 2;
   localparam int CLOCKED_SERIAL_ENABLE_BIT = 7;
   localparam int SHIFT_ORDER_SELECT_BIT = 2;
   localparam int SHIFT_CLOCK_SOURCE_SELECT_BIT = 1;
   localparam int PARITY_ERROR_FLAG_BIT = 2;
   localparam int FRAMING_ERROR_FLAG_BIT = 1;
   localparam int OVERRUN_ERROR_FLAG_BIT = 0;

   // ==========================================================
   // Parity scheme encodings
   localparam logic [1:0] PARITY_NONE = 2'h0;
   localparam logic [1:0] PARITY_ZERO = 2'h1;
   localparam logic [1:0] PARITY_ODD = 2'h2;
   localparam logic [1:0] PARITY_EVEN = 2'h3;

   localparam logic [3:0] CHAR_BITS_7 = 4'h7;
   localparam logic [3:0] CHAR_BITS_8 = 4'h8;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      SMR_MODE_STOPPED,
      SMR_MODE_ASYNC,
      SMR_MODE_CLOCKED,
      SMR_MODE_PROHIBITED
   } smr_mode_t;

   typedef enum logic [1:0] {
      SMR_RX_IDLE,
      SMR_RX_DATA,
      SMR_RX_PARITY,
      SMR_RX_STOP
   } smr_rx_state_t;

   // One finished character as it leaves the link domain
   typedef struct packed {
      logic [7:0] data;
      logic parity_err;
      logic framing_err;
   } smr_rx_result_t;

   // One shared pin as seen from the block
   typedef struct packed {
      logic out;
      logic oe;
   } smr_pin_drive_t;

endpackage

// ### smr_serial_mode_status.sv
// Purpose: Mode decode, shared-pin steering and asynchronous receive
//          error status for a dual-mode serial interface.
// Assumes: Receiver runs on link_clk_i, one rising edge per bit time,
//          present only while frames arrive.
// Notes:   Baud divider, transmit and clocked-serial shifters are outside.
// Function
// RQ1: With all three enables clear, no transfer runs and all three pins go back to the port.
// RQ2: Software programs only the defined stopped, asynchronous and clocked-serial combinations.
// RQ3: Asynchronous mode needs the clocked bits clear, is LSB first, drives TX out and takes RX in.
// RQ4: In asynchronous mode the clock pin is an input only with the external baud source.
// RQ5: Clocked mode needs both async enables clear; direction 0 is MSB first, 1 is LSB first.
// RQ6: Clocked mode takes an external clock at select 0, drives the internal one at 1, drives data out.
// RQ7: In transmit-only clocked use the data input pin stays a port pin.
// RQ8: A read-only 8-bit status register reports async receive errors and resets to 00H.
// RQ9: The status register is undefined while clocked-serial mode is active.
// RQ10: Parity error is set when received parity mismatches the configured scheme.
// RQ11: With zero parity selected, parity is not checked and never flagged.
// RQ12: Framing error is set when the stop bit is not found.
// RQ13: Only one stop bit is checked even when two are configured.
// RQ14: Overrun is set when a character completes before the previous one was read.
// RQ15: Until the buffer is read, every completed reception flags overrun again.
// RQ16: Status flags are rewritten at every completed character.
`timescale 1ns/1ns
module smr_serial_mode_status (
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic link_clk_i,
   input wire logic [15:0] cpu_addr_i,
   input wire logic cpu_wr_i,
   input wire logic cpu_rd_i,
   input wire logic [7:0] cpu_wdata_i,
   output logic [7:0] cpu_rdata_o,
   input wire logic ext_baud_sel_i,
   input wire logic baud_clk_i,
   input wire logic tx_data_i,
   input wire logic clocked_tx_only_i,
   input wire logic port_dir_bit_clk_pin_i,
   input wire logic port_dir_bit_out_pin_i,
   input wire logic port_dir_bit_in_pin_i,
   input wire logic port_latch_clk_pin_i,
   input wire logic port_latch_out_pin_i,
   input wire logic port_latch_in_pin_i,
   input wire logic clk_pin_i,
   output logic clk_pin_o,
   output logic clk_pin_oe_o,
   input wire logic out_pin_i,
   output logic out_pin_o,
   output logic out_pin_oe_o,
   input wire logic in_pin_i,
   output logic in_pin_o,
   output logic in_pin_oe_o,
   output logic [1:0] mode_o,
   output logic shift_msb_first_o,
   output logic ext_clock_in_use_o
);

   // ==========================================================
   // CPU registers
   logic [7:0] amode_q;
   logic [7:0] cmode_q;
   logic [7:0] status_q;
   logic [7:0] status_d;
   logic [7:0] rxbuf_q;
   logic unread_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   wire wr_amode = cpu_wr_i && (cpu_addr_i == smr_pkg::ASYNC_MODE_CONTROL_ADDR);
   wire wr_cmode = cpu_wr_i &&
      (cpu_addr_i == smr_pkg::CLOCKED_SERIAL_MODE_CONTROL_ADDR);
   wire rd_rxbuf = cpu_rd_i && (cpu_addr_i == smr_pkg::RECEIVE_BUFFER_ADDR);

   wire tx_en = amode_q[smr_pkg::ASYNC_TX_ENABLE_BIT];
   wire rx_en = amode_q[smr_pkg::ASYNC_RX_ENABLE_BIT];
   wire [1:0] par_sel = amode_q[smr_pkg::PARITY_SEL_HI_BIT:
                                smr_pkg::PARITY_SEL_LO_BIT];
   wire char8 = amode_q[smr_pkg::CHAR_LENGTH_BIT];
   wire cs_en = cmode_q[smr_pkg::CLOCKED_SERIAL_ENABLE_BIT];
   wire dir_lsb = cmode_q[smr_pkg::SHIFT_ORDER_SELECT_BIT];
   wire cs_int_clk = cmode_q[smr_pkg::SHIFT_CLOCK_SOURCE_SELECT_BIT];

   // ==========================================================
   // Mode decode; a prohibited setting releases the pins like stop
   wire is_stop = !tx_en && !rx_en && !cs_en; // [RQ1]
   wire is_async = (tx_en || rx_en) && !cs_en && !dir_lsb &&
      !cs_int_clk; // [RQ3]
   wire is_clocked = !tx_en && !rx_en && cs_en; // [RQ5]
   smr_pkg::smr_mode_t mode;
   assign mode = is_async ? smr_pkg::SMR_MODE_ASYNC :
      is_clocked ? smr_pkg::SMR_MODE_CLOCKED :
      is_stop ? smr_pkg::SMR_MODE_STOPPED :
      smr_pkg::SMR_MODE_PROHIBITED;

   // ==========================================================
   // Shared pin steering
   wire clk_in_use = (is_async && ext_baud_sel_i) ||
      (is_clocked && !cs_int_clk); // [RQ4] [RQ6]
   wire clk_drive = is_clocked && cs_int_clk; // [RQ6]
   wire out_drive = (is_async && tx_en) || is_clocked; // [RQ3] [RQ6]
   wire in_in_use = (is_async && rx_en) ||
      (is_clocked && !clocked_tx_only_i); // [RQ3] [RQ7]

   // Port direction bit 0 means the port drives the pin
   smr_pkg::smr_pin_drive_t clk_d;
   smr_pkg::smr_pin_drive_t out_d;
   smr_pkg::smr_pin_drive_t in_d;
   // Concatenations follow the struct's field order: out, then oe
   assign clk_d = clk_drive ? {baud_clk_i, 1'b1} :
      clk_in_use ? 2'h0 :
      {port_latch_clk_pin_i, !port_dir_bit_clk_pin_i}; // [RQ1]
   assign out_d = out_drive ? {tx_data_i, 1'b1} :
      {port_latch_out_pin_i, !port_dir_bit_out_pin_i}; // [RQ1]
   assign in_d = in_in_use ? 2'h0 :
      {port_latch_in_pin_i, !port_dir_bit_in_pin_i}; // [RQ1] [RQ7]

   smr_pkg::smr_pin_drive_t clk_q;
   smr_pkg::smr_pin_drive_t out_q;
   smr_pkg::smr_pin_drive_t in_q;
   logic [1:0] mode_q;
   logic msb_first_q;
   logic ext_clk_q;

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         clk_q <= '0;
         out_q <= '0;
         in_q <= '0;
         mode_q <= 2'h0;
         msb_first_q <= 1'b0;
         ext_clk_q <= 1'b0;
      end else begin
         clk_q <= clk_d;
         out_q <= out_d;
         in_q <= in_d;
         mode_q <= mode;
         msb_first_q <= is_clocked && !dir_lsb; // [RQ5] [RQ3]
         ext_clk_q <= clk_in_use;
      end
   end

   assign clk_pin_o = clk_q.out;
   assign clk_pin_oe_o = clk_q.oe;
   assign out_pin_o = out_q.out;
   assign out_pin_oe_o = out_q.oe;
   assign in_pin_o = in_q.out;
   assign in_pin_oe_o = in_q.oe;
   assign mode_o = mode_q;
   assign shift_msb_first_o = msb_first_q;
   assign ext_clock_in_use_o = ext_clk_q;

   // ==========================================================
   // Link domain: configuration in, receive pin in
   logic [1:0] rxen_sync_q;
   logic [1:0] char8_sync_q;
   logic [3:0] par_sync_q;
   logic [1:0] pin_sync_q;

   always_ff @(posedge link_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rxen_sync_q <= 2'h0;
         char8_sync_q <= 2'h0;
         par_sync_q <= 4'h0;
         pin_sync_q <= 2'h3;
      end else begin
         rxen_sync_q <= {rxen_sync_q[0], is_async && rx_en};
         char8_sync_q <= {char8_sync_q[0], char8};
         par_sync_q <= {par_sync_q[1:0], par_sel};
         pin_sync_q <= {pin_sync_q[0], in_pin_i};
      end
   end

   wire l_rx_en = rxen_sync_q[1];
   wire l_char8 = char8_sync_q[1];
   wire [1:0] l_par = par_sync_q[3:2];
   wire l_bit = pin_sync_q[1];

   // ==========================================================
   // Link domain receiver, LSB first
   smr_pkg::smr_rx_state_t st_q;
   smr_pkg::smr_rx_state_t st_d;
   logic [3:0] cnt_q;
   logic [7:0] shf_q;
   logic par_err_q;
   smr_pkg::smr_rx_result_t res_q;
   logic done_tgl_q;

   wire [3:0] nbits = l_char8 ? smr_pkg::CHAR_BITS_8 : smr_pkg::CHAR_BITS_7;
   wire data_last = (cnt_q == nbits - 4'h1);
   wire has_par = (l_par != smr_pkg::PARITY_NONE);
   wire [7:0] data_full = l_char8 ? shf_q : {1'b0, shf_q[7:1]};
   // Odd scheme: data plus parity has odd ones, so xor of all is 1
   wire par_bad = (l_par == smr_pkg::PARITY_ODD) ? !(^data_full ^ l_bit) :
      (l_par == smr_pkg::PARITY_EVEN) ? (^data_full ^ l_bit) :
      1'b0; // [RQ10] [RQ11]

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         smr_pkg::SMR_RX_IDLE: begin
            if (l_rx_en && !l_bit) begin
               st_d = smr_pkg::SMR_RX_DATA;
            end
         end
         smr_pkg::SMR_RX_DATA: begin
            if (data_last) begin
               st_d = has_par ? smr_pkg::SMR_RX_PARITY : smr_pkg::SMR_RX_STOP;
            end
         end
         smr_pkg::SMR_RX_PARITY: st_d = smr_pkg::SMR_RX_STOP;
         smr_pkg::SMR_RX_STOP: st_d = smr_pkg::SMR_RX_IDLE;
      endcase
   end

   always_ff @(posedge link_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_q <= smr_pkg::SMR_RX_IDLE;
         cnt_q <= 4'h0;
         shf_q <= 8'h00;
         par_err_q <= 1'b0;
         res_q <= '0;
         done_tgl_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= (st_q == smr_pkg::SMR_RX_DATA) ? cnt_q + 4'h1 : 4'h0;
         if (st_q == smr_pkg::SMR_RX_DATA) begin
            shf_q <= {l_bit, shf_q[7:1]}; // [RQ3]
         end
         if (st_q == smr_pkg::SMR_RX_IDLE) begin
            par_err_q <= 1'b0;
         end else if (st_q == smr_pkg::SMR_RX_PARITY) begin
            par_err_q <= par_bad; // [RQ10] [RQ11]
         end
         // One stop bit checked whatever the stop length setting
         if (st_q == smr_pkg::SMR_RX_STOP) begin
            res_q <= '{data: data_full, parity_err: par_err_q,
                       framing_err: !l_bit}; // [RQ12] [RQ13]
            done_tgl_q <= !done_tgl_q;
         end
      end
   end

   // ==========================================================
   // Core domain: toggle crossing; result word is stable for a
   // whole bit time after the toggle, well past the sync delay
   logic [2:0] done_sync_q;
   wire done_evt = done_sync_q[2] ^ done_sync_q[1];

   always_comb begin
      status_d = status_q;
      if (done_evt) begin
         status_d = 8'h00;
         status_d[smr_pkg::PARITY_ERROR_FLAG_BIT] = res_q.parity_err;
         status_d[smr_pkg::FRAMING_ERROR_FLAG_BIT] = res_q.framing_err;
         status_d[smr_pkg::OVERRUN_ERROR_FLAG_BIT] = unread_q; // [RQ14] [RQ15]
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         done_sync_q <= 3'h0;
         amode_q <= smr_pkg::ASYNC_MODE_CONTROL_RST;
         cmode_q <= smr_pkg::CLOCKED_SERIAL_MODE_CONTROL_RST;
         status_q <= smr_pkg::ASYNC_RX_ERROR_STATUS_RST; // [RQ8]
         rxbuf_q <= smr_pkg::RECEIVE_BUFFER_RST;
         unread_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         done_sync_q <= {done_sync_q[1:0], done_tgl_q};
         if (wr_amode) begin
            amode_q <= cpu_wdata_i & smr_pkg::ASYNC_MODE_CONTROL_WMASK;
         end
         if (wr_cmode) begin
            cmode_q <= cpu_wdata_i & smr_pkg::CLOCKED_SERIAL_MODE_CONTROL_WMASK;
         end
         status_q <= status_d; // [RQ16] [RQ9]
         if (done_evt) begin
            rxbuf_q <= res_q.data;
         end
         // A completion in the read cycle leaves the new byte unread
         unread_q <= done_evt || (unread_q && !rd_rxbuf); // [RQ15]
         rdata_q <= rdata_d;
      end
   end

   // ==========================================================
   // Read mux; unmapped addresses read zero
   always_comb begin
      rdata_d = 8'h00;
      if (cpu_rd_i) begin
         unique case (cpu_addr_i)
            smr_pkg::ASYNC_MODE_CONTROL_ADDR: rdata_d = amode_q;
            smr_pkg::ASYNC_RX_ERROR_STATUS_ADDR: rdata_d = status_q; // [RQ8]
            smr_pkg::CLOCKED_SERIAL_MODE_CONTROL_ADDR: rdata_d = cmode_q;
            smr_pkg::RECEIVE_BUFFER_ADDR: rdata_d = rxbuf_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   assign cpu_rdata_o = rdata_q;

   // Prohibited settings are software's burden; they report mode 3 and release the pins like stop [RQ2]
   wire unused_pins = clk_pin_i ^ out_pin_i;

endmodule // smr_serial_mode_status

// ### smr_serial_mode_status_sva.sv
// Purpose: Port checks for the serial mode select block
// Assumes: Registered outputs lag their causes by one core cycle
// Notes: Receive status timing is judged by the bench
`timescale 1ns/1ns
module smr_serial_mode_status_sva (
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic [15:0] cpu_addr_i,
   input wire logic cpu_rd_i,
   input wire logic [7:0] cpu_rdata_o,
   input wire logic baud_clk_i,
   input wire logic tx_data_i,
   input wire logic port_dir_bit_clk_pin_i,
   input wire logic clk_pin_o,
   input wire logic clk_pin_oe_o,
   input wire logic out_pin_o,
   input wire logic out_pin_oe_o,
   input wire logic [1:0] mode_o,
   input wire logic shift_msb_first_o,
   input wire logic ext_clock_in_use_o
);
   // ==========================================
   // Properties
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_stat_rd;
      cpu_rd_i && cpu_addr_i == smr_pkg::ASYNC_RX_ERROR_STATUS_ADDR;
   endsequence
   sequence s_clocked;
      mode_o == 2'h2 && $past(mode_o) == 2'h2;
   endsequence
   property p_stop_pins;
      mode_o == 2'h0 && $past(arst_n_i) |->
         clk_pin_oe_o == !$past(port_dir_bit_clk_pin_i);
   endproperty
   property p_stop_quiet;
      mode_o == 2'h0 |-> !ext_clock_in_use_o && !shift_msb_first_o;
   endproperty
   property p_async_lsb;
      mode_o == 2'h1 |-> !shift_msb_first_o && (ext_clock_in_use_o ||
         clk_pin_oe_o == !$past(port_dir_bit_clk_pin_i));
   endproperty
   property p_msb_clocked;
      shift_msb_first_o |-> mode_o == 2'h2;
   endproperty
   property p_ext_clk;
      ext_clock_in_use_o |-> mode_o inside {2'h1, 2'h2} && !clk_pin_oe_o;
   endproperty
   property p_data_out;
      s_clocked |-> out_pin_oe_o && out_pin_o == $past(tx_data_i);
   endproperty
   property p_sck_out;
      s_clocked and clk_pin_oe_o && $past(clk_pin_oe_o) |->
         clk_pin_o == $past(baud_clk_i);
   endproperty
   property p_stat_rd;
      s_stat_rd |=> cpu_rdata_o[7:3] == 5'h00;
   endproperty
   a_stop_pins: assert property (p_stop_pins)
      else $error("clock pin not handed to port when stopped");
   a_stop_quiet: assert property (p_stop_quiet)
      else $error("serial function active when stopped");
   a_async_lsb: assert property (p_async_lsb)
      else $error("async mode not lsb first or clock pin not the port's");
   a_msb_clocked: assert property (p_msb_clocked)
      else $error("msb first outside clocked mode");
   a_ext_clk: assert property (p_ext_clk)
      else $error("clock input use in wrong mode");
   a_data_out: assert property (p_data_out)
      else $error("clocked data out pin not driven from shifter");
   a_sck_out: assert property (p_sck_out)
      else $error("shift clock out not from baud clock");
   a_stat_rd: assert property (p_stat_rd)
      else $error("status upper bits not zero");
endmodule // smr_serial_mode_status_sva

// ### smr_peer.sv
// Purpose: Far-side serial peer sending async frames
// Assumes: One link clock rising edge per bit, idle line high
// Notes: Link clock stands still outside frames
`timescale 1ns/1ns
module smr_peer (
   output logic link_clk_o,
   output logic line_o
);
   initial begin
      link_clk_o = 1'b0;
      line_o = 1'b1;
   end
   task automatic bit_out(input logic b);
      line_o = b;
      #32 link_clk_o = 1'b1;
      #32 link_clk_o = 1'b0;
   endtask
   // Two lead-in idle bits fill the receiver's synchroniser
   task automatic send(input logic [7:0] d, input int nb,
                       input logic has_p, input logic p, input logic stop);
      #7;
      repeat (2) bit_out(1'b1);
      bit_out(1'b0);
      for (int i = 0; i < nb; i++) bit_out(d[i]);
      if (has_p) bit_out(p);
      bit_out(stop);
      repeat (3) bit_out(1'b1);
   endtask
endmodule // smr_peer

// ### tb_serial_mode_select_and_rx_status.sv
// Purpose: Self-checking bench for the serial mode select block
// Assumes: Status settles within 8 core cycles after a frame
// Notes: Port direction of the data input pin is held at 0
`timescale 1ns/1ns
`define CHK(a,b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
   $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_serial_mode_select_and_rx_status;
   logic core_clk_i = 1'b0, arst_n_i = 1'b1, wr = 1'b0, rd = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00, rdata, got, a, c, d;
   logic ext_sel = 1'b0, txonly = 1'b0, dir_i = 1'b0, baud = 1'b0;
   logic txd = 1'b0, dir_c = 1'b1, dir_o = 1'b1;
   logic lat_c = 1'b0, lat_o = 1'b0, lat_i = 1'b0, link_clk, line;
   logic clk_po, clk_oe, out_po, out_oe, in_po, in_oe, msb, extu;
   logic ck, ou, xu, iu;
   logic [6:0] rnd_q;
   logic [1:0] mode, em;
   logic [15:0] tab [9] = '{16'h0000, 16'h8000, 16'h4000, 16'hc000,
      16'h0080, 16'h0082, 16'h0084, 16'h0086, 16'hc080};
   int n_fail = 0, n_compared = 0, unread = 0;
   logic [7:0] exp_q [$];
   always #10 core_clk_i = ~core_clk_i;
   // Copy of the inputs as the design sampled them at this edge
   always @(posedge core_clk_i) begin
      rnd_q <= {baud, txd, dir_c, dir_o, lat_c, lat_o, lat_i};
      #1 {baud, txd, dir_c, dir_o, lat_c, lat_o, lat_i} = 7'($urandom);
   end
   smr_serial_mode_status dut (.core_clk_i(core_clk_i),
      .arst_n_i(arst_n_i), .link_clk_i(link_clk), .cpu_addr_i(addr),
      .cpu_wr_i(wr), .cpu_rd_i(rd), .cpu_wdata_i(wdata),
      .cpu_rdata_o(rdata), .ext_baud_sel_i(ext_sel), .baud_clk_i(baud),
      .tx_data_i(txd), .clocked_tx_only_i(txonly),
      .port_dir_bit_clk_pin_i(dir_c), .port_dir_bit_out_pin_i(dir_o),
      .port_dir_bit_in_pin_i(dir_i), .port_latch_clk_pin_i(lat_c),
      .port_latch_out_pin_i(lat_o), .port_latch_in_pin_i(lat_i),
      .clk_pin_i(clk_oe ? clk_po : 1'b1), .clk_pin_o(clk_po),
      .clk_pin_oe_o(clk_oe), .out_pin_i(out_oe ? out_po : 1'b1),
      .out_pin_o(out_po), .out_pin_oe_o(out_oe),
      .in_pin_i(in_oe ? in_po : line), .in_pin_o(in_po),
      .in_pin_oe_o(in_oe), .mode_o(mode), .shift_msb_first_o(msb),
      .ext_clock_in_use_o(extu));
   smr_peer peer (.link_clk_o(link_clk), .line_o(line));
   // ==========================================
   // Bus tasks and receive model
   task automatic wr_reg(input logic [15:0] ad, input logic [7:0] v);
      @(posedge core_clk_i) #1;
      addr = ad; wdata = v; wr = 1'b1;
      @(posedge core_clk_i) #1 wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [15:0] ad, output logic [7:0] v);
      @(posedge core_clk_i) #1;
      addr = ad; rd = 1'b1;
      @(posedge core_clk_i) #1 rd = 1'b0;
      v = rdata;
   endtask
   task automatic frame(input logic [7:0] m, input logic [7:0] dt,
                        input logic pbad, input logic stop, input logic rb);
      logic p;
      logic [7:0] ex;
      p = ^(dt & {m[3], 7'h7f}) ^ (m[5:4] == smr_pkg::PARITY_ODD) ^ pbad;
      exp_q.push_back({5'h00, m[5] & pbad, ~stop, unread != 0});
      unread = 1;
      peer.send(dt, m[3] ? 8 : 7, m[5:4] != smr_pkg::PARITY_NONE, p, stop);
      repeat (8) @(posedge core_clk_i);
      rd_reg(smr_pkg::ASYNC_RX_ERROR_STATUS_ADDR, got);
      ex = exp_q.pop_front();
      `CHK(got, ex)
      if (rb) begin
         rd_reg(smr_pkg::RECEIVE_BUFFER_ADDR, got);
         `CHK(got, dt & {m[3], 7'h7f})
         unread = 0;
      end
   endtask
   task automatic final_report();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // ==========================================
   // Main sequence
   initial begin
      void'($urandom(76379));
      // A real falling edge, so the link-domain flops reset as well
      #1 arst_n_i = 1'b0;
      #39 arst_n_i = 1'b1;
      rd_reg(smr_pkg::ASYNC_RX_ERROR_STATUS_ADDR, got);
      `CHK(got, smr_pkg::ASYNC_RX_ERROR_STATUS_RST)
      wr_reg(smr_pkg::ASYNC_RX_ERROR_STATUS_ADDR, 8'hff);
      rd_reg(smr_pkg::ASYNC_RX_ERROR_STATUS_ADDR, got);
      `CHK(got, 8'h00)
      rd_reg(16'hff73, got);
      `CHK(got, 8'h00)
      $display("register test done");
      // Last entry is a prohibited setting on purpose
      for (int i = 0; i < 18; i++) begin
         {a, c} = tab[i / 2];
         {ext_sel, txonly} = {2{i[0]}};
         em = c[7] ? (a[7:6] != 0 ? 2'h3 : 2'h2) :
            (a[7:6] != 0 ? 2'h1 : 2'h0);
         ck = em == 2'h2 && c[1];
         ou = (em == 2'h1 && a[7]) || em == 2'h2;
         xu = (em == 2'h1 && i[0]) || (em == 2'h2 && !c[1]);
         iu = (em == 2'h1 && a[6]) || (em == 2'h2 && !i[0]);
         wr_reg(smr_pkg::ASYNC_MODE_CONTROL_ADDR, a);
         wr_reg(smr_pkg::CLOCKED_SERIAL_MODE_CONTROL_ADDR, c);
         repeat (3) @(posedge core_clk_i);
         #2;
         `CHK(mode, em)
         `CHK(msb, em == 2'h2 && !c[2])
         `CHK(extu, xu)
         `CHK(clk_oe, ck || (!xu && !rnd_q[4]))
         `CHK(clk_po, ck ? rnd_q[6] : !xu && rnd_q[2])
         `CHK(out_oe, ou || !rnd_q[3])
         `CHK(out_po, ou ? rnd_q[5] : rnd_q[1])
         `CHK(in_oe, !iu)
         `CHK(in_po, !iu && rnd_q[0])
      end
      wr_reg(smr_pkg::CLOCKED_SERIAL_MODE_CONTROL_ADDR, 8'h00);
      $display("mode test done");
      for (int i = 0; i < 16; i++) begin
         a = {2'b11, i[1:0], i[2], 1'($urandom), 2'b00};
         wr_reg(smr_pkg::ASYNC_MODE_CONTROL_ADDR, a);
         frame(a, 8'($urandom), i[3], 1'($urandom), 1'b1);
      end
      $display("receive error test done");
      wr_reg(smr_pkg::ASYNC_MODE_CONTROL_ADDR, 8'hc8);
      for (int k = 0; k < 5; k++) frame(8'hc8, 8'($urandom), 0, 1, k >= 3);
      $display("overrun test done");
      final_report();
   end
   initial begin
      #1000000 n_fail++;
      final_report();
   end
endmodule // tb_serial_mode_select_and_rx_status
bind smr_serial_mode_status smr_serial_mode_status_sva u_sva (
   .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .cpu_addr_i(cpu_addr_i),
   .cpu_rd_i(cpu_rd_i), .cpu_rdata_o(cpu_rdata_o), .baud_clk_i(baud_clk_i),
   .tx_data_i(tx_data_i), .port_dir_bit_clk_pin_i(port_dir_bit_clk_pin_i),
   .clk_pin_o(clk_pin_o), .clk_pin_oe_o(clk_pin_oe_o), .out_pin_o(out_pin_o),
   .out_pin_oe_o(out_pin_oe_o), .mode_o(mode_o),
   .shift_msb_first_o(shift_msb_first_o),
   .ext_clock_in_use_o(ext_clock_in_use_o));
